//--- reg_host_model.sv
// Host side register access model driving the strobe port
`timescale 1ns/1ps
module reg_host_model (
	input  wire logic                             clk,
	input  wire regulator_voltage_pkg::reg_byte_t rd_data,
	input  wire logic                             rd_valid,
	output      logic                             wr_en, rd_en,
	output      regulator_voltage_pkg::reg_byte_t addr, wr_data
);
	import regulator_voltage_pkg::*;
	initial begin
		{wr_en, rd_en, addr, wr_data} = 18'h0;
	end
	// Released bus shows inverted values so a stale address never looks valid
	task automatic wr(input reg_byte_t a, input reg_byte_t d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		addr <= ~a;
		wr_data <= ~d;
		#1;
	endtask
	task automatic rd(input reg_byte_t a, output reg_byte_t d, output logic v);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		addr <= ~a;
		#1;
		v = rd_valid;
		d = rd_data;
	endtask
endmodule

//--- regulator_voltage_defines.svh
// Offsets, reset values and field positions of the regulator voltage registers
`ifndef REGULATOR_VOLTAGE_DEFINES_SVH
`define REGULATOR_VOLTAGE_DEFINES_SVH
`define REG_A_VOLTAGE_ADDR   8'h06
`define REG_B_VOLTAGE_ADDR   8'h07
`define DUTY_FLOOR_LOW_ADDR  8'h08
`define REG_A_VOLTAGE_RESET  6'h24
`define REG_B_VOLTAGE_RESET  6'h10
`define DUTY_FLOOR_RESET     8'hFF
`define CODE_MSB             5
`define CODE_WIDTH           6
`define LOW_RANGE_LAST       6'h1F
`define MID_RANGE_LAST       6'h3C
`define LOW_BASE_MV          12'h320
`define LOW_STEP_MV          12'h019
`define MID_BASE_MV          12'h640
`define MID_STEP_MV          12'h032
`define TOP_BASE_MV          12'hC1C
`define TOP_STEP_MV          12'h064
`define UP_STEP_PERCENT      8'h08
`endif

//--- regulator_voltage_pkg.sv
// Types shared by the regulator voltage register slice
package regulator_voltage_pkg;
	typedef logic [5:0]  voltage_code_t;
	typedef logic [11:0] millivolt_t;
	typedef logic [7:0]  reg_byte_t;
	typedef enum logic [1:0] {
		ACC_IDLE,
		ACC_WRITE,
		ACC_READ
	} access_t;
endpackage

//--- regulator_voltage_properties.sv
// Port assertions for the regulator voltage register slice
`timescale 1ns/1ps
module regulator_voltage_properties (
	input wire logic clk, rst, wr_en, rd_en, rd_valid, voltage_lock, undervoltage_lockout,
	input wire logic power_good_fault, device_reset_req,
	input wire regulator_voltage_pkg::reg_byte_t addr, wr_data, rd_data, duty_floor_low_bits,
	input wire regulator_voltage_pkg::reg_byte_t otp_duty_floor_low,
	input wire regulator_voltage_pkg::voltage_code_t otp_regulator_a_code, otp_regulator_b_code,
	input wire regulator_voltage_pkg::voltage_code_t regulator_a_voltage_code,
	input wire regulator_voltage_pkg::voltage_code_t regulator_b_voltage_code,
	input wire regulator_voltage_pkg::millivolt_t regulator_a_millivolts
);
	import regulator_voltage_pkg::*;
	logic wr_ok;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	assign wr_ok = wr_en && !undervoltage_lockout && !voltage_lock;
	function automatic millivolt_t dec(voltage_code_t c);
		if (c < 32) return 12'(800 + 25 * c);
		if (c < 61) return 12'(1600 + 50 * (c - 32));
		return 12'(3100 + 100 * (c - 61));
	endfunction
	a_write_a_lands: assert property (
		wr_ok && addr == 8'h06 |=> regulator_a_voltage_code == $past(wr_data[5:0])
	) else $error("Regulator A code not written");
	a_write_b_lands: assert property (
		wr_ok && addr == 8'h07 |=> regulator_b_voltage_code == $past(wr_data[5:0])
	) else $error("Regulator B code not written");
	a_lock_blocks: assert property (
		wr_en && voltage_lock && !undervoltage_lockout && addr[7:1] == 7'h03 |=>
		$stable(regulator_a_voltage_code) && $stable(regulator_b_voltage_code)
	) else $error("Locked code changed");
	a_lockout_reload: assert property (
		undervoltage_lockout |=> regulator_a_voltage_code == $past(otp_regulator_a_code)
		&& regulator_b_voltage_code == $past(otp_regulator_b_code)
		&& duty_floor_low_bits == $past(otp_duty_floor_low)
	) else $error("Lockout did not reload defaults");
	a_floor_readonly: assert property (
		!undervoltage_lockout |=> $stable(duty_floor_low_bits)
	) else $error("Floor byte changed without lockout");
	a_read_code: assert property (
		rd_en && !wr_en && !undervoltage_lockout && addr == 8'h06 |=>
		rd_valid && rd_data == {2'h0, $past(regulator_a_voltage_code)}
	) else $error("Regulator A read wrong");
	a_read_floor: assert property (
		rd_en && !wr_en && !undervoltage_lockout && addr == 8'h08 |=>
		rd_valid && rd_data == $past(duty_floor_low_bits)
	) else $error("Floor read wrong");
	a_decode_a: assert property (
		// Decoder register fills one edge after reset release
		!$past(rst) |-> regulator_a_millivolts == dec($past(regulator_a_voltage_code))
	) else $error("Regulator A decode wrong");
	a_fault_resets: assert property (
		power_good_fault |=> device_reset_req
	) else $error("Power-good fault gave no reset request");
endmodule
bind regulator_voltage_registers regulator_voltage_properties i_props (.*);

//--- regulator_voltage_registers.sv
// Regulator A/B voltage code registers and read-only duty floor low byte
`timescale 1ns/1ps
`include "regulator_voltage_defines.svh"
module regulator_voltage_registers (
	// Clock and reset
	input  wire logic                                 clk,
	input  wire logic                                 rst,
	// Register access from the serial interface
	input  wire logic                                 wr_en,
	input  wire logic                                 rd_en,
	input  wire regulator_voltage_pkg::reg_byte_t     addr,
	input  wire regulator_voltage_pkg::reg_byte_t     wr_data,
	output      regulator_voltage_pkg::reg_byte_t     rd_data,
	output      logic                                 rd_valid,
	// OTP defaults and lockout
	input  wire logic                                 undervoltage_lockout,
	input  wire regulator_voltage_pkg::voltage_code_t otp_regulator_a_code,
	input  wire regulator_voltage_pkg::voltage_code_t otp_regulator_b_code,
	input  wire regulator_voltage_pkg::reg_byte_t     otp_duty_floor_low,
	input  wire logic                                 voltage_lock,
	// Power-good monitoring
	input  wire logic                                 regulator_a_running,
	input  wire logic                                 regulator_b_running,
	input  wire logic                                 power_good_fault,
	// Outputs to the analog and PWM blocks
	output      regulator_voltage_pkg::voltage_code_t regulator_a_voltage_code,
	output      regulator_voltage_pkg::voltage_code_t regulator_b_voltage_code,
	output      regulator_voltage_pkg::millivolt_t    regulator_a_millivolts,
	output      regulator_voltage_pkg::millivolt_t    regulator_b_millivolts,
	output      regulator_voltage_pkg::reg_byte_t     duty_floor_low_bits,
	output      logic                                 step_violation,
	output      logic                                 device_reset_req
);
	import regulator_voltage_pkg::*;

	typedef struct packed {
		voltage_code_t code_a_r;
		voltage_code_t code_b_r;
		reg_byte_t     floor_r;
		reg_byte_t     rd_data_r;
		logic          rd_valid_r;
		logic          step_viol_r;
		logic          dev_rst_r;
		logic          reload_r;
	} regs_state_t;

	regs_state_t st_r;
	regs_state_t st_nxt;
	access_t     acc;

	// True when the new code's millivolts exceed the old code's by more than the allowed percentage
	function automatic logic step_too_large(input voltage_code_t old_c, input voltage_code_t new_c);
		// Wide enough for the top code times 108 percent without wrapping
		logic [19:0] old_v;
		logic [19:0] new_v;
		old_v = {8'h00, code_to_mv(old_c)};
		new_v = {8'h00, code_to_mv(new_c)};
		step_too_large = (new_v * 20'h00064) >
			(old_v * (20'h00064 + {12'h000, `UP_STEP_PERCENT}));
	endfunction

	function automatic millivolt_t code_to_mv(input voltage_code_t c);
		millivolt_t e;
		e = {6'h00, c};
		if (c <= `LOW_RANGE_LAST) begin
			code_to_mv = 12'(`LOW_BASE_MV + e * `LOW_STEP_MV);
		end else if (c <= `MID_RANGE_LAST) begin
			code_to_mv = 12'(`MID_BASE_MV + (e - 12'h020) * `MID_STEP_MV);
		end else begin
			code_to_mv = 12'(`TOP_BASE_MV + (e - 12'h03D) * `TOP_STEP_MV);
		end
	endfunction

	always_comb begin
		if (wr_en) begin
			acc = ACC_WRITE;
		end else if (rd_en) begin
			acc = ACC_READ;
		end else begin
			acc = ACC_IDLE;
		end
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.rd_valid_r = 1'b0;
		st_nxt.step_viol_r = 1'b0;
		st_nxt.dev_rst_r = power_good_fault;
		st_nxt.reload_r = 1'b0;
		// Lockout reload has priority over any host access in the same cycle
		if (undervoltage_lockout) begin
			st_nxt.code_a_r = otp_regulator_a_code;
			st_nxt.code_b_r = otp_regulator_b_code;
			st_nxt.floor_r = otp_duty_floor_low;
			st_nxt.reload_r = 1'b1;
		end else begin
			case (acc)
				ACC_WRITE: begin
					// Spare bits 7:6 and register 08h are not writable
					if (addr == `REG_A_VOLTAGE_ADDR && !voltage_lock) begin
						st_nxt.code_a_r = wr_data[`CODE_MSB:0];
						st_nxt.step_viol_r = regulator_a_running &&
							step_too_large(st_r.code_a_r, wr_data[`CODE_MSB:0]);
					end else if (addr == `REG_B_VOLTAGE_ADDR && !voltage_lock) begin
						st_nxt.code_b_r = wr_data[`CODE_MSB:0];
						st_nxt.step_viol_r = regulator_b_running &&
							step_too_large(st_r.code_b_r, wr_data[`CODE_MSB:0]);
					end
				end
				ACC_READ: begin
					st_nxt.rd_valid_r = 1'b1;
					if (addr == `REG_A_VOLTAGE_ADDR) begin
						st_nxt.rd_data_r = {2'b00, st_r.code_a_r};
					end else if (addr == `REG_B_VOLTAGE_ADDR) begin
						st_nxt.rd_data_r = {2'b00, st_r.code_b_r};
					end else if (addr == `DUTY_FLOOR_LOW_ADDR) begin
						st_nxt.rd_data_r = st_r.floor_r;
					end else begin
						st_nxt.rd_data_r = 8'h00;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r.code_a_r    <= `REG_A_VOLTAGE_RESET;
			st_r.code_b_r    <= `REG_B_VOLTAGE_RESET;
			st_r.floor_r     <= `DUTY_FLOOR_RESET;
			st_r.rd_data_r   <= 8'h00;
			st_r.rd_valid_r  <= 1'b0;
			st_r.step_viol_r <= 1'b0;
			st_r.dev_rst_r   <= 1'b0;
			st_r.reload_r    <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rd_data                  = st_r.rd_data_r;
	assign rd_valid                 = st_r.rd_valid_r;
	assign regulator_a_voltage_code = st_r.code_a_r;
	assign regulator_b_voltage_code = st_r.code_b_r;
	assign duty_floor_low_bits      = st_r.floor_r;
	assign step_violation           = st_r.step_viol_r;
	assign device_reset_req         = st_r.dev_rst_r;

	voltage_decoder u_dec_a (
		.clk        (clk),
		.rst        (rst),
		.code       (st_r.code_a_r),
		.millivolts (regulator_a_millivolts)
	);

	voltage_decoder u_dec_b (
		.clk        (clk),
		.rst        (rst),
		.code       (st_r.code_b_r),
		.millivolts (regulator_b_millivolts)
	);
endmodule

//--- tb_top.sv
// Self-checking bench for the regulator voltage register slice
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module tb_top;
	import regulator_voltage_pkg::*;
	typedef struct {reg_byte_t a, w, r; millivolt_t m;} row_t;
	logic clk, rst, wr_en, rd_en, rd_valid, voltage_lock, undervoltage_lockout, v;
	logic regulator_a_running, regulator_b_running, power_good_fault, step_violation;
	logic device_reset_req;
	reg_byte_t addr, wr_data, rd_data, otp_duty_floor_low, duty_floor_low_bits, d;
	voltage_code_t otp_regulator_a_code, otp_regulator_b_code;
	voltage_code_t regulator_a_voltage_code, regulator_b_voltage_code;
	millivolt_t regulator_a_millivolts, regulator_b_millivolts, mv_seen;
	int error_cnt, comparisons;
	row_t rows[9] = '{'{8'h06, 8'h2A, 8'h2A, 12'h834}, '{8'h06, 8'hFF, 8'h3F, 12'hCE4},
		'{8'h06, 8'h3C, 8'h3C, 12'hBB8}, '{8'h06, 8'h3D, 8'h3D, 12'hC1C},
		'{8'h07, 8'h00, 8'h00, 12'h320}, '{8'h07, 8'h1F, 8'h1F, 12'h627},
		'{8'h07, 8'h20, 8'h20, 12'h640}, '{8'h08, 8'h00, 8'hFF, 12'h0},
		'{8'h0F, 8'h55, 8'h00, 12'h0}};
	regulator_voltage_registers i_dut (.*);
	reg_host_model i_host (.*);
	task automatic conclude();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#1000000;
		error_cnt++;
		conclude();
	end
	initial begin
		{rst, voltage_lock, undervoltage_lockout, power_good_fault} = 4'h8;
		{regulator_a_running, regulator_b_running} = 2'h0;
		{otp_regulator_a_code, otp_regulator_b_code, otp_duty_floor_low} = 20'hA855A;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			i_host.wr(rows[i].a, rows[i].w);
			i_host.rd(rows[i].a, d, v);
			`CHK("rd_data", rows[i].r, d)
			`CHK("rd_valid", 1'b1, v)
			mv_seen = rows[i].a[0] ? regulator_b_millivolts : regulator_a_millivolts;
			if (rows[i].a < 8'h08) `CHK("mv", rows[i].m, mv_seen)
		end
		@(posedge clk) voltage_lock <= 1'b1;
		i_host.wr(8'h06, 8'h01);
		`CHK("locked code", 6'h3D, regulator_a_voltage_code)
		i_host.wr(8'h07, 8'h01);
		`CHK("locked code b", 6'h20, regulator_b_voltage_code)
		@(posedge clk) {voltage_lock, undervoltage_lockout} <= 2'h1;
		i_host.rd(8'h06, d, v);
		`CHK("lockout read", 1'b0, v)
		@(posedge clk) undervoltage_lockout <= 1'b0;
		#1;
		`CHK("otp a", 6'h2A, regulator_a_voltage_code)
		`CHK("otp b", 6'h05, regulator_b_voltage_code)
		`CHK("otp floor", 8'h5A, duty_floor_low_bits)
		// Running regulator: small raise, large raise, then a drop
		@(posedge clk) {regulator_a_running, regulator_b_running} <= 2'h3;
		i_host.wr(8'h06, 8'h2B);
		`CHK("small step", 1'b0, step_violation)
		i_host.wr(8'h06, 8'h30);
		`CHK("large step", 1'b1, step_violation)
		i_host.wr(8'h06, 8'h20);
		`CHK("drop step", 1'b0, step_violation)
		`CHK("drop code", 6'h20, regulator_a_voltage_code)
		i_host.wr(8'h07, 8'h06);
		`CHK("small step b", 1'b0, step_violation)
		i_host.wr(8'h07, 8'h0C);
		`CHK("large step b", 1'b1, step_violation)
		@(posedge clk) power_good_fault <= 1'b1;
		@(posedge clk) power_good_fault <= 1'b0;
		#1;
		`CHK("reset req", 1'b1, device_reset_req)
		@(posedge clk) rst <= 1'b1;
		@(posedge clk) rst <= 1'b0;
		#1;
		`CHK("reset a", 6'h24, regulator_a_voltage_code)
		`CHK("reset b", 6'h10, regulator_b_voltage_code)
		`CHK("reset floor", 8'hFF, duty_floor_low_bits)
		repeat (2) @(posedge clk);
		#1;
		`CHK("reset mv a", 12'h708, regulator_a_millivolts)
		`CHK("reset mv b", 12'h4B0, regulator_b_millivolts)
		conclude();
	end
endmodule

//--- voltage_decoder.sv
// Voltage code to millivolt decoder with registered output
`timescale 1ns/1ps
`include "regulator_voltage_defines.svh"
module voltage_decoder (
	// Clock and reset
	input  wire logic                                 clk,
	input  wire logic                                 rst,
	// Code in, millivolts out
	input  wire regulator_voltage_pkg::voltage_code_t code,
	output      regulator_voltage_pkg::millivolt_t    millivolts
);
	import regulator_voltage_pkg::*;

	typedef struct packed {
		millivolt_t mv_r;
	} dec_state_t;

	dec_state_t st_r;
	dec_state_t st_nxt;
	millivolt_t code_ext;

	assign code_ext   = {6'h00, code};
	assign millivolts = st_r.mv_r;

	// Three piecewise-linear ranges: 25 mV, 50 mV, then 100 mV steps
	always_comb begin
		st_nxt = st_r;
		if (code <= `LOW_RANGE_LAST) begin
			st_nxt.mv_r = 12'(`LOW_BASE_MV + code_ext * `LOW_STEP_MV);
		end else if (code <= `MID_RANGE_LAST) begin
			st_nxt.mv_r = 12'(`MID_BASE_MV + (code_ext - 12'h020) * `MID_STEP_MV);
		end else begin
			st_nxt.mv_r = 12'(`TOP_BASE_MV + (code_ext - 12'h03D) * `TOP_STEP_MV);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule
